// file: design/i2c_slave_port.v
// I2C slave port with clock stretching and strap-derived unique address.
// Operation
// - After a byte is received or sent the port may hold the clock line low while busy.
// - Only the clock low phase right after an acknowledge bit is ever stretched.
// - The port ignores all traffic until boot has set its unique address.
// - The address is 0, 1, strap pin b, strap pin a, analog decode bits, then read/write.
// - Each address bit can be masked and overridden separately on each of the two ports.
// - The analog strap decode maps seven resistor bands and open to fixed codes.
// - Both digital strap pins are sampled together with the analog strap decode.
// - At its unique address the port takes a sub-address byte then commands and reads.
// - The port works at both standard and fast bus rates.
// - As a receiver the port acknowledges its own address and every byte after it, holding data low through clock high.
`timescale 1ns/1ns
`default_nettype none
`include "i2c_port_map.vh"
module i2c_slave_port #(
  parameter PORT_SEL = 0
) (
  input  wire       sys_clk,
  input  wire       sys_rst,
  input  wire       scl_in,
  output reg        scl_out,
  output reg        scl_oe,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  input  wire       strap_pin_a,
  input  wire       strap_pin_b,
  input  wire [2:0] adc_level,
  input  wire       adc_valid,
  input  wire       boot_done,
  input  wire [6:0] port1_mask,
  input  wire [6:0] port1_override,
  input  wire [6:0] port2_mask,
  input  wire [6:0] port2_override,
  input  wire       core_ready,
  input  wire [7:0] core_rdata,
  output reg  [7:0] core_subaddr,
  output reg  [7:0] core_wdata,
  output reg        core_wr,
  output reg        core_rd,
  output reg        byte_busy,
  output reg  [6:0] unique_addr,
  output reg        addr_valid
);
  ////////////////////////////////////////////////////////////////////////////////
  // States of the byte engine.
  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_RECV  = 3'h2;
  localparam ST_SEND  = 3'h3;
  localparam ST_ACK   = 3'h4;
  localparam ST_MACK  = 3'h5;
  localparam ST_HOLD  = 3'h6;
  localparam ST_IGN   = 3'h7;

  wire scl_s;
  wire sda_s;
  wire pin_a_s;
  wire pin_b_s;

  line_sync u_scl (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(scl_in), .pin_sync(scl_s));
  line_sync u_sda (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(sda_in), .pin_sync(sda_s));
  line_sync u_pa  (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(strap_pin_a),
                   .pin_sync(pin_a_s));
  line_sync u_pb  (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(strap_pin_b),
                   .pin_sync(pin_b_s));

  ////////////////////////////////////////////////////////////////////////////////
  // Strap decode and address latch.
  reg [3:0] strap_code;

  // Seven resistor bands and the open pin, as reported by the converter.
  always @* begin
    case (adc_level)
      3'h0:    strap_code = `STRAP_CODE_R0;
      3'h1:    strap_code = `STRAP_CODE_R383K;
      3'h2:    strap_code = `STRAP_CODE_R845K;
      3'h3:    strap_code = `STRAP_CODE_R140K;
      3'h4:    strap_code = `STRAP_CODE_R205K;
      3'h5:    strap_code = `STRAP_CODE_R280K;
      3'h6:    strap_code = `STRAP_CODE_R374K;
      default: strap_code = `STRAP_CODE_OPEN;
    endcase
  end

  // The open code is four bits wide but only three fit; the low three are kept.
  wire [6:0] strap_addr = {`ADDR_BIT7, `ADDR_BIT6, pin_b_s, pin_a_s, strap_code[2:0]};
  wire [6:0] sel_mask   = (PORT_SEL == 0) ? port1_mask : port2_mask;
  wire [6:0] sel_ovr    = (PORT_SEL == 0) ? port1_override : port2_override;
  reg  [6:0] strap_latch;
  reg        strap_taken;

  // Pins are caught in the same cycle the analog decode is valid, and only once.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_latch <= 7'h00;
      strap_taken <= 1'b0;
      unique_addr <= 7'h00;
      addr_valid  <= 1'b0;
    end else begin
      if (adc_valid && !strap_taken) begin
        strap_latch <= strap_addr;
        strap_taken <= 1'b1;
      end
      if (boot_done && strap_taken && !addr_valid) begin
        unique_addr <= (strap_latch & ~sel_mask) | (sel_ovr & sel_mask);
        addr_valid  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus edge detection.
  reg scl_d;
  reg sda_d;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte engine. Sampling on the system clock limits the bus rate to fast mode at 10 MHz.
  reg [2:0] state;
  reg [2:0] bit_cnt;
  reg [7:0] shreg;
  reg       is_read;
  reg       have_sub;
  reg       stretch;
  reg       bit_seen;  // A bit has been clocked in since the last byte boundary.
  reg [2:0] after_hold;

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state        <= ST_IDLE;
      bit_cnt      <= 3'h0;
      shreg        <= 8'h00;
      is_read      <= 1'b0;
      have_sub     <= 1'b0;
      stretch      <= 1'b0;
      bit_seen     <= 1'b0;
      after_hold   <= ST_IDLE;
      scl_out      <= 1'b0;
      scl_oe       <= 1'b0;
      sda_out      <= 1'b0;
      sda_oe       <= 1'b0;
      core_subaddr <= `SUBADDR_RESET;
      core_wdata   <= 8'h00;
      core_wr      <= 1'b0;
      core_rd      <= 1'b0;
      byte_busy    <= 1'b0;
    end else begin
      core_wr <= 1'b0;
      core_rd <= 1'b0;
      scl_oe  <= stretch;
      byte_busy <= stretch;
      if (stop_c) begin
        state   <= ST_IDLE;
        sda_oe  <= 1'b0;
        stretch <= 1'b0;
      end else if (start_c) begin
        // Traffic before the address is set is simply not decoded.
        state    <= addr_valid ? ST_ADDR : ST_IGN;
        bit_cnt  <= 3'h0;
        bit_seen <= 1'b0;
        have_sub <= 1'b0;
        sda_oe   <= 1'b0;
        stretch  <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_RECV: begin
            if (scl_rise) begin
              shreg    <= {shreg[6:0], sda_s};
              bit_cnt  <= bit_cnt + 3'h1;
              bit_seen <= 1'b1;
            end
            // The clock fall that follows a start carries no bit and must not end a byte.
            if (scl_fall && bit_cnt == 3'h0 && bit_seen) begin
              bit_seen <= 1'b0;
              if (state == ST_ADDR && shreg[7:1] != unique_addr) begin
                state <= ST_IGN;
              end else begin
                sda_oe <= 1'b1;
                state  <= ST_ACK;
                if (state == ST_ADDR) begin
                  is_read <= shreg[0];
                end else if (!have_sub) begin
                  core_subaddr <= shreg;
                  have_sub     <= 1'b1;
                end else begin
                  core_wdata <= shreg;
                  core_wr    <= 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            // Data stays low through the whole high phase; released on the next fall.
            if (scl_fall) begin
              sda_oe <= 1'b0;
              if (!core_ready) begin
                stretch    <= 1'b1;
                after_hold <= is_read ? ST_SEND : ST_RECV;
                state      <= ST_HOLD;
              end else if (is_read) begin
                shreg   <= core_rdata;
                sda_oe  <= ~core_rdata[7];
                core_rd <= 1'b1;
                bit_cnt <= 3'h1;
                state   <= ST_SEND;
              end else begin
                bit_cnt <= 3'h0;
                state   <= ST_RECV;
              end
            end
          end
          ST_HOLD: begin
            // The clock is let go one cycle after the core is seen ready, as scl_oe follows stretch.
            if (core_ready) begin
              stretch <= 1'b0;
              if (after_hold == ST_SEND) begin
                shreg   <= core_rdata;
                sda_oe  <= ~core_rdata[7];
                core_rd <= 1'b1;
                bit_cnt <= 3'h1;
              end else begin
                bit_cnt <= 3'h0;
              end
              state <= after_hold;
            end
          end
          ST_SEND: begin
            if (scl_fall) begin
              if (bit_cnt == 3'h0) begin
                sda_oe <= 1'b0;
                state  <= ST_MACK;
              end else begin
                sda_oe  <= ~shreg[3'h7 - bit_cnt];
                bit_cnt <= bit_cnt + 3'h1;
              end
            end
          end
          ST_MACK: begin
            // A master that does not acknowledge ends the read; the data line stays free.
            if (scl_rise) begin
              state <= sda_s ? ST_IGN : ST_ACK;
            end
          end
          ST_IDLE, ST_IGN: begin
            sda_oe <= 1'b0;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // i2c_slave_port
`default_nettype wire

// file: design/line_sync.v
// Two-flip-flop synchroniser for one pin input.
`timescale 1ns/1ns
`default_nettype none
module line_sync (
  input  wire sys_clk,
  input  wire sys_rst,
  input  wire pin_in,
  output reg  pin_sync
);
  reg stage1;

  // The first stage is read only by the second stage, keeping metastability contained.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1   <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      stage1   <= pin_in;
      pin_sync <= stage1;
    end
  end
endmodule // line_sync
`default_nettype wire

// file: include/i2c_port_map.vh
// Constants for the I2C slave port with strap-derived unique address.
`ifndef I2C_PORT_MAP_VH
`define I2C_PORT_MAP_VH
`define ADDR_BIT7          1'h0
`define ADDR_BIT6          1'h1
`define STRAP_CODE_W       4
`define STRAP_CODE_OPEN    4'hF
`define STRAP_CODE_R0      4'h0
`define STRAP_CODE_R383K   4'h1
`define STRAP_CODE_R845K   4'h2
`define STRAP_CODE_R140K   4'h3
`define STRAP_CODE_R205K   4'h4
`define STRAP_CODE_R280K   4'h5
`define STRAP_CODE_R374K   4'h6
`define ADC_LEVEL_W        3
`define ADC_LEVEL_OPEN     3'h7
`define SUBADDR_RESET      8'h00
`define READ_DATA_RESET    8'h00
`endif

// file: verification/i2c_master_model.sv
// Behavioural I2C bus master driving the clock and data lines open-drain.
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model #(
  parameter int STRETCH_EXTRA_NS = 4000
) (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output var  logic scl_low,
  output var  logic sda_low
);
  // Both lines start released so the pull-ups hold them high.
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One 800 ns pulse; a stretch lengthens the low phase and then the high phase too.
  task automatic clk_pulse(output logic seen);
    time  t0;
    logic stretched;
    #300 scl_low = 1'b0;
    t0 = $time;
    wait (scl_in === 1'b1);
    stretched = ($time != t0);
    #300 seen = sda_in;
    if (stretched) #(STRETCH_EXTRA_NS);
    #100 scl_low = 1'b1;
  endtask
  // Start: data falls while the clock is high.
  task automatic start;
    #100 sda_low = 1'b1;
    #400 scl_low = 1'b1;
  endtask
  // Stop: data rises while the clock is high, then the bus rests.
  task automatic stop;
    #100 sda_low = 1'b1;
    #300 scl_low = 1'b0;
    wait (scl_in === 1'b1);
    #400 sda_low = 1'b0;
    #400;
  endtask
  // Sends a byte most significant bit first and reports the acknowledge.
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      #100 sda_low = !d[i];
      clk_pulse(b);
    end
    #100 sda_low = 1'b0;
    clk_pulse(b);
    ack = !b;
  endtask
  // Receives a byte most significant bit first, then acknowledges it or refuses it.
  task automatic recv_byte(input logic ack_it, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      #100 sda_low = 1'b0;
      clk_pulse(b);
      d[i] = b;
    end
    #100 sda_low = ack_it;
    clk_pulse(b);
  endtask
endmodule // i2c_master_model
`default_nettype wire

// file: verification/i2c_slave_port_props.sv
// Concurrent checks on the ports of the I2C slave port.
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_port_props (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       core_ready,
  input wire logic       core_wr,
  input wire logic       boot_done,
  input wire logic       addr_valid,
  input wire logic [6:0] unique_addr,
  input wire logic [6:0] port1_mask
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // A stretch must end within three cycles once the core can go on.
  sequence s_release;
    ##[1:3] !scl_oe;
  endsequence
  sequence s_ready_in_stretch;
    $rose(core_ready) && scl_oe;
  endsequence
  a_scl_drive_low: assert property (scl_oe |-> !scl_out)
    else $error("clock line driven high");
  a_stretch_cause: assert property ($rose(scl_oe) |-> !$past(core_ready, 2))
    else $error("stretch began while core was ready");
  a_stretch_release: assert property (s_ready_in_stretch |-> s_release)
    else $error("stretch held after core ready");
  a_sda_drive_low: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_quiet_before_addr: assert property (!addr_valid |-> !sda_oe && !core_wr)
    else $error("bus answered before address set");
  a_addr_after_boot: assert property ($rose(addr_valid) |-> $past(boot_done))
    else $error("address valid without boot");
  a_addr_held: assert property (addr_valid |=> addr_valid && $stable(unique_addr))
    else $error("address changed before reset");
  a_addr_fixed_bits: assert property (addr_valid |->
    ((unique_addr[6:5] ^ 2'h1) & ~port1_mask[6:5]) == 2'h0)
    else $error("fixed address bits wrong");
  a_write_pulse: assert property (core_wr |=> !core_wr)
    else $error("write strobe longer than one cycle");
endmodule // i2c_slave_port_props
bind i2c_slave_port i2c_slave_port_props u_props (.*);
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the I2C slave port.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic       sys_clk = 1'b0, sys_rst = 1'b1, adc_valid, boot_done, core_ready;
  logic       strap_pin_a, strap_pin_b, scl_out, scl_oe, sda_out, sda_oe, core_wr, core_rd;
  logic       byte_busy, addr_valid, scl_low, sda_low, ack, stretch_seen = 1'b0;
  logic [2:0] adc_level;
  logic [6:0] port1_mask, port1_override, port2_mask, port2_override, unique_addr, exp_addr;
  logic [7:0] core_rdata, core_subaddr, core_wdata, sub, d, rd;
  logic [7:0] exp_q[$];
  wire        scl_in = !(scl_oe | scl_low);
  wire        sda_in = !(sda_oe | sda_low);
  integer     errors = 0, check_count = 0, seed = 45, cycles = 0, rd_count = 0;
  i2c_slave_port #(.PORT_SEL(0)) u_i2c_slave_port (.*);
  i2c_master_model u_i2c_master_model (.*);
  always #50 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Straps settle through the synchronisers before the decode is flagged valid.
  task automatic do_reset(input logic [2:0] lvl);
    sys_rst = 1'b1;
    boot_done = 1'b0;
    adc_valid = 1'b0;
    adc_level = lvl;
    {strap_pin_a, strap_pin_b} = 2'($random(seed));
    port1_mask = (lvl == 3'h5) ? 7'h0C : 7'h00;
    {port1_override, port2_mask, port2_override} = 21'($random(seed));
    core_rdata = 8'($random(seed));
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  // Open strap reads back as all ones in the three address bits.
  task automatic form_addr;
    exp_addr = ({2'h1, strap_pin_b, strap_pin_a, adc_level} & ~port1_mask) |
               (port1_override & port1_mask);
    adc_valid = 1'b1;
    @(negedge sys_clk);
    adc_valid = 1'b0;
    boot_done = 1'b1;
    repeat (4) @(negedge sys_clk);
    cmp8("addr", {1'b0, exp_addr}, {1'b0, unique_addr});
  endtask
  task automatic send(input logic [7:0] b, input logic e, input string what);
    u_i2c_master_model.send_byte(b, ack);
    cmp8(what, {7'h0, e}, {7'h0, ack});
  endtask
  // Every write strobe is matched against the oldest noted byte; a hang ends the run.
  // Outputs are looked at on the falling edge, clear of the edge that launches them.
  always @(negedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      errors++;
      end_of_test;
    end
    if (core_wr === 1'b1) cmp8("wdata", exp_q.size() ? exp_q.pop_front() : 8'hXX, core_wdata);
    if (scl_oe === 1'b1) stretch_seen = 1'b1;
    if (core_rd === 1'b1) rd_count = rd_count + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_ready = 1'b1;
    do_reset(3'h0);
    u_i2c_master_model.start;
    send(8'h8A, 1'b0, "early ack");
    u_i2c_master_model.stop;
    for (int l = 0; l < 8; l++) begin
      do_reset(l[2:0]);
      form_addr;
    end
    // A second decode and strap change must not move the latched address.
    {strap_pin_a, strap_pin_b, adc_level} = ~{strap_pin_a, strap_pin_b, adc_level};
    repeat (4) @(negedge sys_clk);
    adc_valid = 1'b1;
    repeat (4) @(negedge sys_clk);
    adc_valid = 1'b0;
    cmp8("held addr", {1'b0, exp_addr}, {1'b0, unique_addr});
    u_i2c_master_model.start;
    send({~exp_addr, 1'b0}, 1'b0, "wrong addr");
    u_i2c_master_model.stop;
    // Core stays busy past the address acknowledge, so the port must stretch there.
    sub = 8'($random(seed));
    d = 8'($random(seed));
    core_ready = 1'b0;
    fork
      begin
        repeat (100) @(negedge sys_clk);
        cmp8("busy", 8'h01, {7'h0, byte_busy});
        repeat (20) @(negedge sys_clk);
        core_ready = 1'b1;
      end
    join_none
    u_i2c_master_model.start;
    send({exp_addr, 1'b0}, 1'b1, "addr ack");
    send(sub, 1'b1, "sub ack");
    exp_q.push_back(d);
    send(d, 1'b1, "data ack");
    exp_q.push_back(~d);
    send(~d, 1'b1, "data ack");
    u_i2c_master_model.stop;
    // Two bytes are read; refusing the second one makes the port let go of the data line.
    u_i2c_master_model.start;
    send({exp_addr, 1'b1}, 1'b1, "read addr ack");
    u_i2c_master_model.recv_byte(1'b1, rd);
    cmp8("rdata", core_rdata, rd);
    u_i2c_master_model.recv_byte(1'b0, rd);
    cmp8("rdata", core_rdata, rd);
    u_i2c_master_model.stop;
    cmp8("reads", 8'h02, 8'(rd_count));
    cmp8("subaddr", sub, core_subaddr);
    cmp8("stretch", 8'h01, {7'h0, stretch_seen});
    cmp8("pending", 8'h00, 8'(exp_q.size()));
    end_of_test;
  end
endmodule // tb
`default_nettype wire
